// >>> hdl/cpt_timer.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - counter advances on clock divided 1,2,4,8,32 or chosen external pin edge
// - clear selection 00 lets the counter run free and wrap every 65536 counts
// - clear selection 01 or 10 zeroes counter on match, period register plus one
// - run bit 1 starts counting, 0 stops it
// - equality of counter and register A or B drives its pin to set level
// - each pin separately compare output or left as port pin
// - match action low, high or toggle; same level leaves the pin alone
// - after configuring, pin holds level chosen by its action bits before match
// - match fires once at the matching count update, not again until next tick
// - stopping keeps pins except pwm pin A; action write reinitialises only low or high pins
// - clear on match at FFFF rolls to 0000 and sets overflow
// - interrupt request on either compare match and on overflow
// - with buffering on, buffer value loads into compare register on its match
// - pwm uses both registers for pin A only, pin B stays a port
// - pwm pin A goes high on match A, low on match B
// - pwm with equal registers keeps the output level
// - clearing on A or B allows duty from 0% to 100%
// - pwm select bit enters pwm, overriding the pin action settings
// - stopped pwm pin A starts high, low when clearing on register B
// - counter is readable at any time and writable by software
module cpt_timer
	import cpt_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic count_run_bit_i,
	input wire logic [2:0] clk_src_sel_i,
	input wire logic [1:0] ext_edge_sel_i,
	input wire logic ext_clk_pin_a_i,
	input wire logic ext_clk_pin_b_i,
	input wire logic [1:0] clear_sel_i,
	input wire logic pwm_select_bit_i,
	input wire logic [1:0] pin_a_action_i,
	input wire logic [1:0] pin_b_action_i,
	input wire logic action_wr_i,
	input wire logic buf_a_en_i,
	input wire logic buf_b_en_i,
	input wire logic [15:0] buf_a_i,
	input wire logic [15:0] buf_b_i,
	input wire logic cmp_a_wr_i,
	input wire logic cmp_b_wr_i,
	input wire logic [15:0] cmp_wdata_i,
	input wire logic count_wr_i,
	input wire logic [15:0] count_wdata_i,
	input wire logic ovf_clr_i,
	output logic [15:0] timer_count_o,
	output logic [15:0] compare_reg_a_o,
	output logic [15:0] compare_reg_b_o,
	output logic wave_pin_a_o,
	output logic wave_pin_a_oe_o,
	output logic wave_pin_b_o,
	output logic wave_pin_b_oe_o,
	output logic match_a_o,
	output logic match_b_o,
	output logic overflow_flag_o,
	output logic irq_req_o
);

	// ****************************************
	// helper functions
	// ****************************************

	// level after a compare match for one action code
	function automatic logic match_level(input logic [1:0] act, input logic cur);
		case (act)
			CPT_ACT_LOW: match_level = 1'b0;
			CPT_ACT_HIGH: match_level = 1'b1;
			CPT_ACT_TOG: match_level = ~cur;
			default: match_level = cur;
		endcase
	endfunction

	// level shown before the first match: opposite of the match level
	function automatic logic init_level(input logic [1:0] act, input logic cur);
		case (act)
			CPT_ACT_LOW: init_level = 1'b1;
			CPT_ACT_HIGH: init_level = 1'b0;
			default: init_level = cur;
		endcase
	endfunction

	// ****************************************
	// state
	// ****************************************
	logic [4:0] prescale;
	logic [2:0] ext_a_sync;
	logic [2:0] ext_b_sync;
	logic [15:0] count;
	logic [15:0] cmp_a;
	logic [15:0] cmp_b;
	logic pin_a;
	logic pin_b;
	logic ovf_flag;

	// ****************************************
	// count source
	// ****************************************

	// free-running prescaler; divided rates are one-cycle enables
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prescale <= CPT_PRE_RST;
		end else begin
			prescale <= prescale + 5'h01;
		end
	end

	// pins pass two flops; the third stage only keeps the old level
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_a_sync <= 3'h0;
			ext_b_sync <= 3'h0;
		end else begin
			ext_a_sync <= {ext_a_sync[1:0], ext_clk_pin_a_i};
			ext_b_sync <= {ext_b_sync[1:0], ext_clk_pin_b_i};
		end
	end

	wire logic ext_now = (clk_src_sel_i == CPT_SRC_EXTB) ? ext_b_sync[1] : ext_a_sync[1];
	wire logic ext_old = (clk_src_sel_i == CPT_SRC_EXTB) ? ext_b_sync[2] : ext_a_sync[2];
	wire logic ext_rise = ext_now & ~ext_old;
	wire logic ext_fall = ~ext_now & ext_old;
	// edge 1x counts both edges; pulses shorter than a clock cycle can be lost
	wire logic ext_edge = (ext_edge_sel_i == CPT_EDGE_RISE) ? ext_rise :
		(ext_edge_sel_i == CPT_EDGE_FALL) ? ext_fall : (ext_rise | ext_fall);

	logic src_pulse;
	// source selection
	always_comb begin
		case (clk_src_sel_i)
			CPT_SRC_DIV1: src_pulse = 1'b1;
			CPT_SRC_DIV2: src_pulse = prescale[0];
			CPT_SRC_DIV4: src_pulse = &prescale[1:0];
			CPT_SRC_DIV8: src_pulse = &prescale[2:0];
			CPT_SRC_DIV32: src_pulse = &prescale;
			CPT_SRC_EXTA: src_pulse = ext_edge;
			CPT_SRC_EXTB: src_pulse = ext_edge;
			default: src_pulse = 1'b0;
		endcase
	end

	wire logic tick = count_run_bit_i & src_pulse;

	// ****************************************
	// match, clear and overflow
	// ****************************************
	wire logic match_a = tick & (count == cmp_a);
	wire logic match_b = tick & (count == cmp_b);
	wire logic clr_a = (clear_sel_i == CPT_CLR_A) & match_a;
	wire logic clr_b = (clear_sel_i == CPT_CLR_B) & match_b;
	wire logic clr_hit = clr_a | clr_b;
	// a clear at FFFF lands on 0000 exactly like a wrap
	wire logic ovf = tick & (count == CPT_COUNT_MAX);
	wire logic cmp_eq = (cmp_a == cmp_b);
	wire logic pwm = pwm_select_bit_i;

	wire logic [15:0] next_count = count_wr_i ? count_wdata_i :
		!tick ? count :
		clr_hit ? CPT_COUNT_RST :
		count + 16'h0001;

	// counter register; software write wins over a tick
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count <= CPT_COUNT_RST;
		end else begin
			count <= next_count;
		end
	end

	// compare registers with optional buffer load on their own match
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmp_a <= CPT_CMP_RST;
			cmp_b <= CPT_CMP_RST;
		end else begin
			if (cmp_a_wr_i) begin
				cmp_a <= cmp_wdata_i;
			end else if (match_a && buf_a_en_i) begin
				cmp_a <= buf_a_i;
			end
			if (cmp_b_wr_i) begin
				cmp_b <= cmp_wdata_i;
			end else if (match_b && buf_b_en_i) begin
				cmp_b <= buf_b_i;
			end
		end
	end

	// sticky overflow; a set in the clearing cycle wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ovf_flag <= 1'b0;
		end else begin
			ovf_flag <= ovf | (ovf_flag & ~ovf_clr_i);
		end
	end

	// ****************************************
	// waveform pins
	// ****************************************

	// stopped pwm preloads from the clear source only
	wire logic pwm_init = (clear_sel_i != CPT_CLR_B);
	wire logic pwm_next_a = !count_run_bit_i ? pwm_init :
		cmp_eq ? pin_a :
		match_a ? 1'b1 :
		match_b ? 1'b0 : pin_a;
	// action writes only reload low or high actions; toggle keeps level
	wire logic cmp_next_a = action_wr_i ? init_level(pin_a_action_i, pin_a) :
		match_a ? match_level(pin_a_action_i, pin_a) : pin_a;
	wire logic cmp_next_b = action_wr_i ? init_level(pin_b_action_i, pin_b) :
		match_b ? match_level(pin_b_action_i, pin_b) : pin_b;
	wire logic next_pin_a = pwm ? pwm_next_a : cmp_next_a;
	wire logic next_pin_b = pwm ? pin_b : cmp_next_b;

	// pin levels live in flops so stopping leaves them untouched, except pin A in pwm, which preloads
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_a <= 1'b0;
			pin_b <= 1'b0;
		end else begin
			pin_a <= next_pin_a;
			pin_b <= next_pin_b;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign timer_count_o = count;
	assign compare_reg_a_o = cmp_a;
	assign compare_reg_b_o = cmp_b;
	assign wave_pin_a_o = pin_a;
	assign wave_pin_b_o = pin_b;
	assign wave_pin_a_oe_o = pwm | (pin_a_action_i != CPT_ACT_PORT);
	assign wave_pin_b_oe_o = !pwm & (pin_b_action_i != CPT_ACT_PORT);
	assign match_a_o = match_a;
	assign match_b_o = match_b;
	assign overflow_flag_o = ovf_flag;
	assign irq_req_o = match_a | match_b | ovf;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	clear_on_a_a: assert property (
		clear_sel_i == CPT_CLR_A && match_a && !count_wr_i |=> count == 16'h0000)
		else $error("counter not cleared on match A");

	free_wrap_a: assert property (
		clear_sel_i == CPT_CLR_NONE && tick && count == 16'hffff && !count_wr_i
		|=> count == 16'h0000 && ovf_flag)
		else $error("free-run wrap wrong");

	ffff_clear_ovf_a: assert property (
		clr_hit && count == CPT_COUNT_MAX && !count_wr_i
		|-> ovf ##1 (count == 16'h0000 && ovf_flag))
		else $error("clear at FFFF gave no overflow");

	stop_hold_a: assert property (
		!count_run_bit_i && !count_wr_i |=> count == $past(count))
		else $error("counter moved while stopped");

	match_once_a: assert property (
		match_a_o && !count_wr_i |-> timer_count_o == compare_reg_a_o && irq_req_o
		##1 (timer_count_o != $past(timer_count_o) || timer_count_o == CPT_COUNT_RST))
		else $error("match A not tied to a count update");

	pwm_high_a: assert property (
		pwm && count_run_bit_i && match_a && !cmp_eq |=> wave_pin_a_o)
		else $error("pwm pin not high after match A");

	pwm_low_a: assert property (
		pwm && count_run_bit_i && match_b && !cmp_eq |=> !wave_pin_a_o)
		else $error("pwm pin not low after match B");

	pwm_equal_a: assert property (
		pwm && count_run_bit_i && cmp_eq |=> wave_pin_a_o == $past(wave_pin_a_o))
		else $error("pwm level moved with equal registers");

	pwm_init_a: assert property (
		pwm && !count_run_bit_i |=> wave_pin_a_o == ($past(clear_sel_i) != CPT_CLR_B))
		else $error("stopped pwm initial level wrong");

	pin_b_port_a: assert property (
		pwm |-> !wave_pin_b_oe_o && wave_pin_a_oe_o)
		else $error("pwm pin enables wrong");

	low_action_a: assert property (
		!pwm && !action_wr_i && match_b && pin_b_action_i == CPT_ACT_LOW |=> !wave_pin_b_o)
		else $error("low action not applied");

	buf_load_a: assert property (
		match_a && buf_a_en_i && !cmp_a_wr_i |=> cmp_a == $past(buf_a_i))
		else $error("buffer not loaded on match A");

	pwm_match_c: cover property (pwm && match_a ##[1:300] pwm && match_b);
	overflow_c: cover property (ovf && clear_sel_i == CPT_CLR_NONE);
	toggle_c: cover property (!pwm && match_a && pin_a_action_i == CPT_ACT_TOG);
	ext_count_c: cover property (tick && clk_src_sel_i == CPT_SRC_EXTA);

endmodule // cpt_timer
`default_nettype wire

// >>> hdl/cpt_pkg.sv
`default_nettype none
package cpt_pkg;

	// ****************************************
	// counter clear selection
	// ****************************************
	localparam logic [1:0] CPT_CLR_NONE = 2'h0;
	localparam logic [1:0] CPT_CLR_A = 2'h1;
	localparam logic [1:0] CPT_CLR_B = 2'h2;

	// ****************************************
	// compare-match pin actions
	// ****************************************
	localparam logic [1:0] CPT_ACT_PORT = 2'h0;
	localparam logic [1:0] CPT_ACT_LOW = 2'h1;
	localparam logic [1:0] CPT_ACT_HIGH = 2'h2;
	localparam logic [1:0] CPT_ACT_TOG = 2'h3;

	// ****************************************
	// external edge selection
	// ****************************************
	localparam logic [1:0] CPT_EDGE_RISE = 2'h0;
	localparam logic [1:0] CPT_EDGE_FALL = 2'h1;

	// ****************************************
	// count source selection
	// ****************************************
	typedef enum logic [2:0] {
		CPT_SRC_DIV1 = 3'b000,
		CPT_SRC_DIV2 = 3'b001,
		CPT_SRC_DIV4 = 3'b010,
		CPT_SRC_DIV8 = 3'b011,
		CPT_SRC_DIV32 = 3'b100,
		CPT_SRC_EXTA = 3'b101,
		CPT_SRC_EXTB = 3'b110
	} cpt_src_t;

	// ****************************************
	// reset values and limits
	// ****************************************
	localparam logic [15:0] CPT_COUNT_RST = 16'h0000;
	localparam logic [15:0] CPT_COUNT_MAX = 16'hffff;
	localparam logic [15:0] CPT_CMP_RST = 16'hffff;
	localparam logic [4:0] CPT_PRE_RST = 5'h00;

endpackage
`default_nettype wire

// >>> tb/cpt_timer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module cpt_timer_tb_top;
	import cpt_pkg::*;
	typedef struct {int id; logic [15:0] val;} cpt_note_t;
	logic clk_i = 1'b0, rst_i = 1'b1, run = 1'b0, pwm = 1'b0, awr = 1'b0, bae = 1'b0, bbe = 1'b0;
	logic xa = 1'b0, xb = 1'b0, cwa = 1'b0, cwb = 1'b0, cwr = 1'b0, oclr = 1'b0;
	logic [2:0] src = 3'h0;
	logic [1:0] edg = 2'h0, clr = 2'h0, act_a = 2'h0, act_b = 2'h0;
	logic [15:0] bufa = 16'h0, bufb = 16'h0, cdat = 16'h0, wdat = 16'h0, v;
	wire logic [15:0] cnt, ra, rb;
	wire logic pa, pao, pb, pbo, ma, mb, ovf, irq;
	string names [11] = '{"count", "cmp_a", "cmp_b", "pin_a", "pin_a_oe", "pin_b", "pin_b_oe",
		"match_a", "match_b", "ovf", "irq"};
	cpt_note_t notes [$];
	event note_ev;
	int fails = 0;
	int comparisons = 0;
	int n;

	// observed outputs, indexed like the note ids
	function automatic logic [15:0] seen(int id);
		case (id)
			0: seen = cnt;
			1: seen = ra;
			2: seen = rb;
			3: seen = {15'h0, pa};
			4: seen = {15'h0, pao};
			5: seen = {15'h0, pb};
			6: seen = {15'h0, pbo};
			7: seen = {15'h0, ma};
			8: seen = {15'h0, mb};
			9: seen = {15'h0, ovf};
			default: seen = {15'h0, irq};
		endcase
	endfunction

	// one clock for everything
	always #5 clk_i = ~clk_i;

	cpt_timer cpt_timer_i (.clk_i(clk_i), .rst_i(rst_i), .count_run_bit_i(run), .clk_src_sel_i(src),
		.ext_edge_sel_i(edg), .ext_clk_pin_a_i(xa), .ext_clk_pin_b_i(xb), .clear_sel_i(clr),
		.pwm_select_bit_i(pwm), .pin_a_action_i(act_a), .pin_b_action_i(act_b), .action_wr_i(awr),
		.buf_a_en_i(bae), .buf_b_en_i(bbe), .buf_a_i(bufa), .buf_b_i(bufb), .cmp_a_wr_i(cwa),
		.cmp_b_wr_i(cwb), .cmp_wdata_i(cdat), .count_wr_i(cwr), .count_wdata_i(wdat),
		.ovf_clr_i(oclr), .timer_count_o(cnt), .compare_reg_a_o(ra), .compare_reg_b_o(rb),
		.wave_pin_a_o(pa), .wave_pin_a_oe_o(pao), .wave_pin_b_o(pb), .wave_pin_b_oe_o(pbo),
		.match_a_o(ma), .match_b_o(mb), .overflow_flag_o(ovf), .irq_req_o(irq));

	// ****************************************
	// checking and reporting
	// ****************************************
	task automatic check(string nm, logic [15:0] got, logic [15:0] want);
		comparisons++;
		if (got !== want) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, want, got);
		end
	endtask

	task automatic complete_run();
		$display("fails %0d comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// the 1 ns delay lets combinational outputs settle after input changes
	task automatic exp(int id, logic [15:0] val);
		#1;
		notes.push_back('{id, val});
		-> note_ev;
	endtask

	// watcher drains every note that is pending
	always @(note_ev) begin
		while (notes.size() > 0) begin
			check(names[notes[0].id], seen(notes[0].id), notes[0].val);
			void'(notes.pop_front());
		end
	end

	// ****************************************
	// stimulus helpers
	// ****************************************
	task automatic cyc(int k);
		repeat (k) @(negedge clk_i);
	endtask

	// bounded wait for a pulse; a hang ends the run as a failure
	task automatic wait_sig(int id, output int k);
		k = 0;
		while (seen(id) !== 16'h0001) begin
			cyc(1);
			k++;
			if (k > 300) begin
				fails++;
				complete_run();
			end
		end
	endtask

	// w: 0 counter, 1 compare a, 2 compare b
	task automatic wr(int w, logic [15:0] d);
		cdat = d;
		wdat = d;
		cwr = (w == 0);
		cwa = (w == 1);
		cwb = (w == 2);
		cyc(1);
		{cwr, cwa, cwb} = 3'h0;
		// idle cycle so back-to-back writes never re-raise a strobe in one step
		cyc(1);
	endtask

	task automatic act_wr(logic [1:0] a, logic [1:0] b);
		act_a = a;
		act_b = b;
		awr = 1'b1;
		cyc(1);
		awr = 1'b0;
		cyc(1);
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		void'($urandom(32'h8eeb8d4a));
		cyc(3);
		rst_i = 1'b0;
		exp(0, CPT_COUNT_RST);
		exp(1, CPT_CMP_RST);
		exp(9, 16'h0);
		// write, run and stop
		v = 16'($urandom_range(32'h8000));
		wr(0, v);
		exp(0, v);
		run = 1'b1;
		cyc(5);
		run = 1'b0;
		exp(0, v + 16'h5);
		cyc(3);
		exp(0, v + 16'h5);
		// source code 7 selects nothing, so running must not count
		src = 3'h7;
		run = 1'b1;
		cyc(3);
		run = 1'b0;
		exp(0, v + 16'h5);
		// 64 cycles is a multiple of every divider, so prescaler phase does not matter
		for (int s = 1; s < 5; s++) begin
			src = 3'(s);
			wr(0, 16'h0);
			run = 1'b1;
			cyc(64);
			run = 1'b0;
			exp(0, 16'(64 >> ((s == 4) ? 5 : s)));
		end
		// pin a rising, pin b falling, pin b both edges; both edges count twice per pulse
		for (int s = 5; s < 8; s++) begin
			src = (s == 5) ? 3'h5 : 3'h6;
			edg = 2'(s - 5);
			wr(0, 16'h0);
			run = 1'b1;
			for (int k = 0; k < 3; k++) begin
				{xa, xb} = 2'h3;
				cyc(3);
				{xa, xb} = 2'h0;
				cyc(3);
			end
			run = 1'b0;
			exp(0, (s == 7) ? 16'h6 : 16'h3);
		end
		// clear on a, toggle, buffer reload, period
		src = 3'h0;
		v = 16'($urandom_range(20, 5));
		wr(1, v);
		clr = CPT_CLR_A;
		act_wr(CPT_ACT_TOG, CPT_ACT_PORT);
		bufa = v + 16'h3;
		bae = 1'b1;
		wr(0, 16'h0);
		run = 1'b1;
		wait_sig(7, n);
		exp(0, v);
		exp(10, 16'h1);
		cyc(1);
		exp(0, 16'h0);
		exp(3, 16'h1);
		exp(1, v + 16'h3);
		exp(7, 16'h0);
		wait_sig(7, n);
		check("period_a", 16'(n), v + 16'h3);
		cyc(1);
		exp(3, 16'h0);
		run = 1'b0;
		bae = 1'b0;
		// clear on b, low action on pin b, pin a back to port
		wr(2, 16'h6);
		clr = CPT_CLR_B;
		act_wr(CPT_ACT_PORT, CPT_ACT_LOW);
		exp(5, 16'h1);
		exp(6, 16'h1);
		exp(4, 16'h0);
		wr(0, 16'h0);
		run = 1'b1;
		wait_sig(8, n);
		check("period_b", 16'(n), 16'h6);
		cyc(1);
		exp(5, 16'h0);
		wait_sig(8, n);
		cyc(1);
		exp(5, 16'h0);
		run = 1'b0;
		cyc(2);
		exp(5, 16'h0);
		// toggle write keeps the level, low write reinitialises to high
		act_wr(CPT_ACT_PORT, CPT_ACT_TOG);
		exp(5, 16'h0);
		act_wr(CPT_ACT_PORT, CPT_ACT_LOW);
		exp(5, 16'h1);
		// free-run wrap, then clear on a at ffff
		clr = CPT_CLR_NONE;
		wr(0, 16'hfffe);
		run = 1'b1;
		cyc(1);
		exp(10, 16'h1);
		cyc(1);
		exp(0, 16'h0);
		exp(9, 16'h1);
		run = 1'b0;
		oclr = 1'b1;
		cyc(1);
		oclr = 1'b0;
		exp(9, 16'h0);
		wr(1, 16'hffff);
		clr = CPT_CLR_A;
		wr(0, 16'hfffe);
		run = 1'b1;
		cyc(2);
		run = 1'b0;
		exp(0, 16'h0);
		exp(9, 16'h1);
		// pwm: stopped levels, set and clear, equal registers
		pwm = 1'b1;
		clr = CPT_CLR_B;
		cyc(1);
		exp(3, 16'h0);
		exp(6, 16'h0);
		clr = CPT_CLR_A;
		cyc(1);
		exp(3, 16'h1);
		exp(4, 16'h1);
		clr = CPT_CLR_B;
		wr(1, 16'h3);
		wr(2, 16'h9);
		wr(0, 16'h0);
		run = 1'b1;
		wait_sig(7, n);
		cyc(1);
		exp(3, 16'h1);
		wait_sig(8, n);
		cyc(1);
		exp(3, 16'h0);
		run = 1'b0;
		wr(1, 16'h5);
		wr(2, 16'h5);
		wr(0, 16'h0);
		run = 1'b1;
		wait_sig(7, n);
		cyc(1);
		exp(3, 16'h0);
		// second reset in mid-run
		rst_i = 1'b1;
		run = 1'b0;
		cyc(2);
		rst_i = 1'b0;
		exp(0, CPT_COUNT_RST);
		exp(2, CPT_CMP_RST);
		exp(9, 16'h0);
		cyc(2);
		complete_run();
	end
endmodule // cpt_timer_tb_top
`default_nettype wire
